/* File: hw/fda_pkg.sv */
package fda_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int FDA_AW = 8;
  localparam int FDA_DW = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [FDA_AW-1:0] FDA_OFS_FAULT0 = 8'h00;
  localparam logic [FDA_AW-1:0] FDA_OFS_FAULT1 = 8'h04;
  localparam logic [FDA_AW-1:0] FDA_OFS_CONFIG = 8'h08;
  localparam logic [FDA_AW-1:0] FDA_OFS_CTRL = 8'h0c;
  localparam logic [FDA_AW-1:0] FDA_OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Fault register fields
  // ----------------------------------------------------------------
  localparam int FDA_FAULT_W = 15;
  localparam int FB_UV = 0;
  localparam int FB_OV = 1;
  localparam int FB_TSD = 2;
  localparam int FB_HOT = 3;
  localparam int FB_COLD = 4;
  localparam int FB_SHORT = 5;
  localparam int FB_OPEN = 5;
  localparam int FB_STALL = 6;
  localparam int FB_SUMMARY = 15;
  localparam logic [FDA_FAULT_W-1:0] FDA_FAULT_RESET = 15'h0000;

  // ----------------------------------------------------------------
  // Control, config and status fields
  // ----------------------------------------------------------------
  localparam int CB_DIAGNOSTIC_OUTPUT_PIN_CLR = 0;
  localparam int CB_FAULT_RST = 1;
  localparam int CFG_SEL_LSB = 0;
  localparam int SB_BRIDGE_EN = 0;
  localparam int SB_THRESH_LOW = 1;
  localparam int SB_FAULT_FLAG_N = 2;
  localparam int SB_ARMED = 3;
  localparam int SB_VDD_UV = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FDA_DIAGNOSTIC_OUTPUT_PIN_FAULT = 2'h0,
    FDA_DIAGNOSTIC_OUTPUT_PIN_STALL = 2'h1,
    FDA_DIAGNOSTIC_OUTPUT_PIN_PWM = 2'h2,
    FDA_DIAGNOSTIC_OUTPUT_PIN_TEMP = 2'h3
  } fda_diagnostic_output_pin_sel_t;

  localparam fda_diagnostic_output_pin_sel_t FDA_CONFIG_RESET = FDA_DIAGNOSTIC_OUTPUT_PIN_FAULT;

  typedef enum logic [1:0] {
    FDA_ARM_WAIT = 2'b01,
    FDA_ARM_DONE = 2'b10
  } fda_arm_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [FDA_AW-1:0] adr;
    logic [3:0] sel;
    logic [FDA_DW-1:0] dat;
  } fda_wb_req_t;

  typedef struct packed {
    logic [FDA_DW-1:0] dat;
    logic ack;
  } fda_wb_rsp_t;

  typedef struct packed {
    logic vbb_ov;
    logic vbb_uv;
    logic regulator_output_uv;
    logic vdd_uv;
    logic temp_hot;
    logic temp_cold;
    logic overtemp;
    logic bridge_short;
    logic bridge_open;
  } fda_mon_t;

  localparam int FDA_MON_W = $bits(fda_mon_t);

endpackage : fda_pkg

/* File: hw/fda_sync.sv */
module fda_sync #(
  parameter int W = 1
) (
  input logic sys_clk,
  input logic reset,
  input logic [W-1:0] async_in,
  output logic [W-1:0] stable_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] stable_next;

  // Accept a bit only when stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      stable_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : stable_reg[i];
    end
  end

  // Three-stage chain plus filtered output
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;

endmodule : fda_sync

/* File: hw/fda_fault_latch.sv */
module fda_fault_latch #(
  parameter int W = 15
) (
  input logic sys_clk,
  input logic cold_reset,
  input logic [W-1:0] set_in,
  input logic clear,
  output logic [W-1:0] bits_out
);

  logic [W-1:0] bits_reg;
  logic [W-1:0] bits_next;

  // Sticky bits, a new event beats the clear
  always_comb
  begin
    bits_next = clear ? set_in : (bits_reg | set_in);
  end

  // Only the first power-up resets these bits
  always_ff @(posedge sys_clk or posedge cold_reset)
  begin
    if (cold_reset)
    begin
      bits_reg <= '0;
    end
    else
    begin
      bits_reg <= bits_next;
    end
  end

  assign bits_out = bits_reg;

endmodule : fda_fault_latch

/* File: hw/fda_top.sv */
// Notes on behaviour
// - Diagnostic pin shows fault flag after reset
// - Fault flag low while fault or short
// - Pin may carry stall, PWM or temperature
// - Bit 15 ORs all fault bits except stall
// - Summary flag out when strobe falls
// - Fault bits stick until diagnostic reset
// - Overvoltage disables outputs, non-latched
// - Motor undervoltage flags, selects low threshold
// - No motor undervoltage selects high threshold
// - Regulator undervoltage disables outputs, non-latched
// - Logic undervoltage disables outputs, no summary
// - Logic reset spares the fault bits
// - Shared undervoltage bit ORs both monitors
// - High threshold held until supply first good
//
// Added by the designer: the Wishbone register port and the address map.
module fda_top (
  input logic sys_clk,
  input logic reset,
  input logic cold_reset,
  input fda_pkg::fda_wb_req_t wb_req,
  output fda_pkg::fda_wb_rsp_t wb_rsp,
  input fda_pkg::fda_mon_t mon_pins,
  input logic stall_detect_n,
  input logic pwm_on_phase_a,
  input logic serial_strobe_n,
  output logic diagnostic_output_pin,
  output logic diagnostic_output_pin_analog_sel,
  output logic bridge_enable,
  output logic regulator_output_uv_thresh_low,
  output logic serial_sdo_first
);
  import fda_pkg::*;

  // Clock and reset for all checks below
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset || cold_reset);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  fda_mon_t mon;
  logic [FDA_MON_W:0] pin_sync;
  logic strobe_n_s;

  fda_sync #(
    .W(FDA_MON_W + 1)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({!serial_strobe_n, mon_pins}),
    .stable_out(pin_sync)
  );

  assign mon = fda_mon_t'(pin_sync[FDA_MON_W-1:0]);
  assign strobe_n_s = !pin_sync[FDA_MON_W]; // Stored inverted, reset reads as idle

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  fda_wb_rsp_t rsp_reg;
  fda_wb_rsp_t rsp_next;
  fda_diagnostic_output_pin_sel_t sel_reg;
  fda_diagnostic_output_pin_sel_t sel_next;
  fda_arm_t arm_reg;
  fda_arm_t arm_next;
  logic short_reg;
  logic short_next;
  logic summary_reg;
  logic summary_next;
  logic pin_reg;
  logic pin_next;
  logic analog_reg;
  logic analog_next;
  logic bridge_reg;
  logic bridge_next;
  logic thresh_reg;
  logic thresh_next;
  logic sdo_reg;
  logic sdo_next;
  logic [3:0] settle_reg;
  logic [3:0] settle_next;
  logic settled;
  logic bus_req;
  logic wr_take;
  logic diagnostic_output_pin_clear;
  logic fault_reset;
  logic fault_present;
  logic disable_cause;
  logic [FDA_FAULT_W-1:0] set0;
  logic [FDA_FAULT_W-1:0] set1;
  logic [FDA_FAULT_W-1:0] fault0_q;
  logic [FDA_FAULT_W-1:0] fault1_q;
  logic [FDA_FAULT_W-1:0] summary_mask;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // Write acts at the edge where the master sees ack
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign wr_take = bus_req && wb_req.we && rsp_reg.ack && wb_req.sel[0];
  assign diagnostic_output_pin_clear = wr_take && (wb_req.adr == FDA_OFS_CTRL) && wb_req.dat[CB_DIAGNOSTIC_OUTPUT_PIN_CLR];
  assign fault_reset = wr_take && (wb_req.adr == FDA_OFS_CTRL) && wb_req.dat[CB_FAULT_RST];

  // ----------------------------------------------------------------
  // Fault capture
  // ----------------------------------------------------------------

  // Event vectors for both diagnostic registers
  always_comb
  begin
    set0 = '0;
    set1 = '0;
    set0[FB_UV] = mon.vbb_uv | mon.regulator_output_uv;
    set1[FB_UV] = mon.vbb_uv | mon.regulator_output_uv;
    set0[FB_OV] = mon.vbb_ov;
    set1[FB_OV] = mon.vbb_ov;
    set0[FB_TSD] = mon.overtemp;
    set1[FB_TSD] = mon.overtemp;
    set0[FB_HOT] = mon.temp_hot;
    set1[FB_HOT] = mon.temp_hot;
    set0[FB_COLD] = mon.temp_cold;
    set1[FB_COLD] = mon.temp_cold;
    set0[FB_SHORT] = mon.bridge_short;
    set1[FB_OPEN] = mon.bridge_open;
    set1[FB_STALL] = !stall_detect_n;
  end

  // Sticky banks, untouched by the logic reset
  fda_fault_latch #(
    .W(FDA_FAULT_W)
  ) u_fault0 (
    .sys_clk(sys_clk),
    .cold_reset(cold_reset),
    .set_in(set0),
    .clear(diagnostic_output_pin_clear),
    .bits_out(fault0_q)
  );

  fda_fault_latch #(
    .W(FDA_FAULT_W)
  ) u_fault1 (
    .sys_clk(sys_clk),
    .cold_reset(cold_reset),
    .set_in(set1),
    .clear(diagnostic_output_pin_clear),
    .bits_out(fault1_q)
  );

  // Stall bit stays out of the summary
  assign summary_mask = ~(FDA_FAULT_W'(1) << FB_STALL);

  // ----------------------------------------------------------------
  // Protection and pin logic
  // ----------------------------------------------------------------

  // Live fault and output disable causes, plus the latched short
  always_comb
  begin
    fault_present = mon.vbb_ov | mon.vbb_uv | mon.regulator_output_uv | mon.temp_hot
      | mon.temp_cold | mon.overtemp | mon.bridge_open | short_reg;
    disable_cause = mon.vbb_ov | mon.regulator_output_uv | mon.vdd_uv | mon.overtemp
      | short_reg;
    settled = settle_reg[3]; // Sync chain refilled since reset
  end

  // Next values for protection, pin and bus state
  always_comb
  begin
    short_next = fault_reset ? mon.bridge_short : (short_reg | mon.bridge_short);
    settle_next = {settle_reg[2:0], 1'b1};
    bridge_next = settled && !disable_cause;
    summary_next = |((fault0_q | fault1_q) & summary_mask);
    sdo_next = strobe_n_s ? 1'b0 : summary_reg;
    arm_next = arm_reg;
    thresh_next = 1'b0;
    case (arm_reg)
      FDA_ARM_WAIT:
      begin
        if (settled && !mon.vbb_uv)
        begin
          arm_next = FDA_ARM_DONE;
        end
      end
      FDA_ARM_DONE: thresh_next = mon.vbb_uv;
      default: arm_next = FDA_ARM_WAIT;
    endcase
    analog_next = 1'b0;
    case (sel_reg)
      FDA_DIAGNOSTIC_OUTPUT_PIN_FAULT: pin_next = !fault_present;
      FDA_DIAGNOSTIC_OUTPUT_PIN_STALL: pin_next = stall_detect_n;
      FDA_DIAGNOSTIC_OUTPUT_PIN_PWM: pin_next = pwm_on_phase_a;
      FDA_DIAGNOSTIC_OUTPUT_PIN_TEMP:
      begin
        pin_next = 1'b0;
        analog_next = 1'b1;
      end
      default: pin_next = !fault_present;
    endcase
    sel_next = sel_reg;
    if (wr_take && (wb_req.adr == FDA_OFS_CONFIG))
    begin
      sel_next = fda_diagnostic_output_pin_sel_t'(wb_req.dat[CFG_SEL_LSB +: 2]);
    end
    rsp_next.ack = bus_req && !rsp_reg.ack;
    rsp_next.dat = '0;
    if (bus_req && !rsp_reg.ack && !wb_req.we)
    begin
      case (wb_req.adr)
        FDA_OFS_FAULT0: rsp_next.dat = {16'h0000, summary_reg, fault0_q};
        FDA_OFS_FAULT1: rsp_next.dat = {16'h0000, summary_reg, fault1_q};
        FDA_OFS_CONFIG: rsp_next.dat = {30'h0, sel_reg};
        FDA_OFS_STATUS:
        begin
          rsp_next.dat[SB_BRIDGE_EN] = bridge_reg;
          rsp_next.dat[SB_THRESH_LOW] = thresh_reg;
          rsp_next.dat[SB_FAULT_FLAG_N] = !fault_present;
          rsp_next.dat[SB_ARMED] = (arm_reg == FDA_ARM_DONE);
          rsp_next.dat[SB_VDD_UV] = mon.vdd_uv;
        end
        default: rsp_next.dat = '0;
      endcase
    end
  end

  // Register all logic state; pin shows fault flag out of reset
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rsp_reg <= '0;
      sel_reg <= FDA_CONFIG_RESET;
      arm_reg <= FDA_ARM_WAIT;
      short_reg <= 1'b0;
      summary_reg <= 1'b0;
      pin_reg <= 1'b1;
      analog_reg <= 1'b0;
      bridge_reg <= 1'b0;
      thresh_reg <= 1'b0;
      sdo_reg <= 1'b0;
      settle_reg <= '0;
    end
    else
    begin
      rsp_reg <= rsp_next;
      sel_reg <= sel_next;
      arm_reg <= arm_next;
      short_reg <= short_next;
      summary_reg <= summary_next;
      pin_reg <= pin_next;
      analog_reg <= analog_next;
      bridge_reg <= bridge_next;
      thresh_reg <= thresh_next;
      sdo_reg <= sdo_next;
      settle_reg <= settle_next;
    end
  end

  assign wb_rsp = rsp_reg;
  assign diagnostic_output_pin = pin_reg;
  assign diagnostic_output_pin_analog_sel = analog_reg;
  assign bridge_enable = bridge_reg;
  assign regulator_output_uv_thresh_low = thresh_reg;
  assign serial_sdo_first = sdo_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_low;
    (sel_reg == FDA_DIAGNOSTIC_OUTPUT_PIN_FAULT && (mon.vbb_ov || short_reg)) |=> !pin_reg;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("fault flag not low during fault");

  property p_sel_stall;
    (sel_reg == FDA_DIAGNOSTIC_OUTPUT_PIN_STALL) |=> (pin_reg == $past(stall_detect_n));
  endproperty
  a_sel_stall: assert property (p_sel_stall)
    else $error("diagnostic pin does not follow stall");

  property p_summary;
    ((fault0_q[FB_OV] || fault1_q[FB_OPEN]) && !diagnostic_output_pin_clear) |=> ##1 summary_reg;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary flag missing");

  property p_sdo;
    !strobe_n_s |=> (sdo_reg == $past(summary_reg));
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("first serial bit is not summary");

  property p_sticky;
    !diagnostic_output_pin_clear |=> ((fault0_q & $past(fault0_q)) == $past(fault0_q));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault bit lost without diagnostic reset");

  property p_ov_off;
    (mon.vbb_ov || mon.regulator_output_uv || mon.vdd_uv) |=> !bridge_reg;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("outputs not disabled on supply fault");

  property p_uv_runs;
    (mon.vbb_uv && !disable_cause) |=> bridge_reg;
  endproperty
  a_uv_runs: assert property (p_uv_runs)
    else $error("motor undervoltage disabled outputs");

  property p_thresh;
    (arm_reg == FDA_ARM_DONE) |=> (thresh_reg == $past(mon.vbb_uv));
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold select does not follow motor undervoltage");

  property p_arm_hold;
    (arm_reg == FDA_ARM_WAIT) |=> !thresh_reg;
  endproperty
  a_arm_hold: assert property (p_arm_hold)
    else $error("low threshold before supply first good");

  property p_uv_bit;
    (mon.vbb_uv || mon.regulator_output_uv) |=> (fault0_q[FB_UV] && fault1_q[FB_UV]);
  endproperty
  a_uv_bit: assert property (p_uv_bit)
    else $error("shared undervoltage bit not set");

  property p_short_hold;
    (short_reg && !fault_reset) |=> (short_reg && !bridge_reg);
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("short released without fault reset");

endmodule : fda_top

/* File: verification/fda_host_model.sv */
module fda_host_model (
  input logic sys_clk,
  input fda_pkg::fda_wb_rsp_t wb_rsp,
  output fda_pkg::fda_wb_req_t wb_req,
  output logic serial_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import fda_pkg::*;

  // Idle bus, strobe released
  initial
  begin
    wb_req = '0;
    serial_strobe_n = 1'b1;
  end

  // ------------------------------------------------------------
  // Classic single bus cycle, held until ack
  // ------------------------------------------------------------
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                      output logic [31:0] rdat);
    rdat = 'x;
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
    @(posedge sys_clk);
    // Wait for ack however long, the bench watchdog bounds it
    while (wb_rsp.ack !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask : xfer

  // Chip select level
  task automatic strobe(input logic v);
    @(posedge sys_clk);
    serial_strobe_n <= v;
  endtask : strobe
endmodule : fda_host_model

/* File: verification/fda_top_tb_top.sv */
module fda_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fda_pkg::*;

  logic sys_clk, reset, cold_reset, stall_detect_n, pwm_on_phase_a, serial_strobe_n;
  logic diagnostic_output_pin, diagnostic_output_pin_analog_sel, bridge_enable, regulator_output_uv_thresh_low;
  logic serial_sdo_first, short_l, armed, f;
  fda_wb_req_t wb_req;
  fda_wb_rsp_t wb_rsp;
  fda_mon_t mon_pins, m;
  logic [14:0] exp0, exp1;
  logic [31:0] seed, q;
  int fails, checked;

  fda_top fda_top_inst (.sys_clk(sys_clk), .reset(reset), .cold_reset(cold_reset),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .mon_pins(mon_pins), .stall_detect_n(stall_detect_n),
    .pwm_on_phase_a(pwm_on_phase_a), .serial_strobe_n(serial_strobe_n),
    .diagnostic_output_pin(diagnostic_output_pin), .diagnostic_output_pin_analog_sel(diagnostic_output_pin_analog_sel),
    .bridge_enable(bridge_enable), .regulator_output_uv_thresh_low(regulator_output_uv_thresh_low),
    .serial_sdo_first(serial_sdo_first));

  fda_host_model fda_host_model_inst (.sys_clk(sys_clk), .wb_rsp(wb_rsp), .wb_req(wb_req),
    .serial_strobe_n(serial_strobe_n));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Sticky bits one monitor vector raises
  function automatic logic [14:0] bits_of(input fda_mon_t v, input logic bank1);
    logic [14:0] b;
    b = '0;
    b[FB_UV] = v.vbb_uv | v.regulator_output_uv;
    b[FB_OV] = v.vbb_ov;
    b[FB_TSD] = v.overtemp;
    b[FB_HOT] = v.temp_hot;
    b[FB_COLD] = v.temp_cold;
    b[FB_SHORT] = bank1 ? v.bridge_open : v.bridge_short;
    return b;
  endfunction : bits_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    fda_host_model_inst.xfer(1'b0, a, 32'h0, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    fda_host_model_inst.xfer(1'b1, a, d, dummy);
  endtask : wr

  // Diagnostic clear, model follows
  task automatic diagnostic_output_pin_clear();
    wr(FDA_OFS_CTRL, 32'h1);
    exp0 = '0;
    exp1 = '0;
  endtask : diagnostic_output_pin_clear

  task automatic check_regs();
    logic s;
    s = |{exp0, exp1[5:0]};
    rd(FDA_OFS_FAULT0, q);
    check(q, {16'h0, s, exp0});
    rd(FDA_OFS_FAULT1, q);
    check(q, {16'h0, s, exp1});
  endtask : check_regs

  // Drive monitors, let sync settle, compare outputs
  task automatic apply(input fda_mon_t v);
    logic en;
    @(posedge sys_clk);
    mon_pins <= v;
    repeat (9) @(posedge sys_clk);
    short_l = short_l | v.bridge_short;
    armed = armed | !v.vbb_uv;
    exp0 = exp0 | bits_of(v, 1'b0);
    exp1 = exp1 | bits_of(v, 1'b1);
    f = !(v.vbb_ov | v.vbb_uv | v.regulator_output_uv | v.temp_hot | v.temp_cold | v.overtemp);
    f = f & !(v.bridge_open | short_l);
    en = !(v.vbb_ov | v.regulator_output_uv | v.vdd_uv | v.overtemp | short_l);
    check(bridge_enable, en);
    check(diagnostic_output_pin, f);
    check(regulator_output_uv_thresh_low, armed & v.vbb_uv);
    rd(FDA_OFS_STATUS, q);
    check(q, {27'h0, v.vdd_uv, armed, f, armed & v.vbb_uv, en});
    check_regs();
  endtask : apply

  task automatic strobe_probe();
    fda_host_model_inst.strobe(1'b0);
    repeat (6) @(posedge sys_clk);
    check(serial_sdo_first, |{exp0, exp1[5:0]});
    fda_host_model_inst.strobe(1'b1);
    repeat (6) @(posedge sys_clk);
    check(serial_sdo_first, 32'h0);
  endtask : strobe_probe

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {reset, cold_reset, stall_detect_n} = 3'h7;
    pwm_on_phase_a = 1'b0;
    mon_pins = '0;
    {exp0, exp1, short_l, armed} = '0;
    {fails, checked} = '0;
    seed = 32'h315f;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    cold_reset <= 1'b0;
    apply('0);
    // Each monitor alone, then random mixes
    for (int i = 0; i < 15; i++)
    begin
      diagnostic_output_pin_clear();
      seed = xorshift(seed);
      m = (i < 9) ? fda_mon_t'(9'h1 << i) : fda_mon_t'(seed[8:0]);
      apply(m);
      strobe_probe();
      apply('0);
      if (short_l)
      begin
        wr(FDA_OFS_CTRL, 32'h2);
        short_l = 1'b0;
        apply('0);
      end
    end
    // Diagnostic pin source selection
    diagnostic_output_pin_clear();
    for (int s = 0; s < 4; s++)
    begin
      wr(FDA_OFS_CONFIG, 32'(s));
      rd(FDA_OFS_CONFIG, q);
      check(q, 32'(s));
      repeat (4)
      begin
        seed = xorshift(seed);
        stall_detect_n <= seed[0];
        pwm_on_phase_a <= seed[1];
        exp1[FB_STALL] = exp1[FB_STALL] | !seed[0];
        repeat (3) @(posedge sys_clk);
        check(diagnostic_output_pin, s == 1 ? seed[0] : s == 2 ? seed[1] : s == 0);
        check(diagnostic_output_pin_analog_sel, s == 3);
      end
    end
    stall_detect_n <= 1'b1;
    wr(FDA_OFS_CONFIG, 32'h0);
    wr(FDA_OFS_FAULT0, 32'hffff);
    check_regs();
    rd(FDA_OFS_STATUS, q);
    check(q, {27'h0, 1'b0, armed, 1'b1, 1'b0, 1'b1});
    rd(8'h40, q);
    check(q, 32'h0);
    // Logic reset with motor supply low
    apply(fda_mon_t'(9'h080));
    wr(FDA_OFS_CONFIG, 32'h2);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    armed = 1'b0;
    rd(FDA_OFS_CONFIG, q);
    check(q, 32'h0);
    apply(fda_mon_t'(9'h080));
    apply('0);
    apply(fda_mon_t'(9'h080));
    apply('0);
    complete_run();
  end
endmodule : fda_top_tb_top
